//--- logic/tmrch_channel.sv
/*
  One 16-bit timer channel: command register, mode register in capture
  or waveform view, counter with clock selection and gating, capture
  latches, compare and period registers, and two I/O line controllers.
  Assumes all inputs are synchronous to i_clk; the clock sources and
  lines are sampled levels, and i_ce low freezes every flip-flop.
*/
`timescale 1ns/1ps
`default_nettype none

// Contract
// [RQ1] Command bit 2 written one: counter to zero, clock started; code only clears the halt (enable kept), and in up-down reverses instead.
// [RQ2] Command bit 1 written one: counter clock disabled.
// [RQ3] Command bit 0 written one enables clock unless bit 1 also one.
// [RQ4] Zero command bits do nothing; command register reads nothing.
// [RQ5] Config bit 15 picks capture (0) or waveform (1) view.
// [RQ6] Capture: bits 17:16, 19:18 pick line A edge loading A, B.
// [RQ7] Capture: bit 14 lets period match restart the counter.
// [RQ8] Capture: bit 10 picks line A (1) or B (0) as trigger.
// [RQ9] Capture: bits 9:8 pick trigger edge none/rise/fall/both.
// [RQ10] Capture: bit 7 disables counter clock on latch B load.
// [RQ11] Capture: bit 6 stops counter clock on latch B load.
// [RQ12] Bits 5:4 gate selected clock with external clock 0-2.
// [RQ13] Bit 3 makes counting happen on falling selected-clock edge.
// [RQ14] Bits 2:0 pick internal clocks 1-5 or external clocks 0-2.
// [RQ15] Waveform: line B actions for trigger, event, period, B match.
// [RQ16] Waveform: line A actions for trigger, event, period, A match.
// [RQ17] Waveform: bits 14:13 pick up/up-down, with or without restart.
// [RQ18] Waveform: bit 12 lets external event restart the counter.
// [RQ19] Waveform: bits 11:10 pick line B (input) or external clock.
// [RQ20] Waveform: bits 9:8 pick event edge none/rise/fall/both.
// [RQ21] Waveform: bit 7 disables counter clock on period match.
// [RQ22] Waveform: bit 6 stops counter clock on period match.
// [RQ23] Up-down without restart spans 0 to 0xffff; trigger reverses.
// [RQ24] Stopped clock resumes on trigger; disabled needs enable command.
module tmrch_channel (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic [4:0]  i_internal_clk,
  input  wire logic [2:0]  i_ext_clock,
  input  wire logic        i_io_line_a,
  output logic             o_io_line_a,
  output logic             o_io_line_a_oe_n,
  input  wire logic        i_io_line_b,
  output logic             o_io_line_b,
  output logic             o_io_line_b_oe_n
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic prev, input logic cur);
    case (sel)
      2'b01:   edge_hit = ~prev & cur;
      2'b10:   edge_hit = prev & ~cur;
      2'b11:   edge_hit = prev ^ cur;
      default: edge_hit = 1'b0;
    endcase
  endfunction
  function automatic logic apply_act(input logic [1:0] act,
                                     input logic cur);
    case (act)
      2'b01:   apply_act = 1'b1;
      2'b10:   apply_act = 1'b0;
      2'b11:   apply_act = ~cur;
      default: apply_act = cur;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0]             cfg_r;
  logic [15:0]             count_r, compare_a_r, latch_b_r, period_r;
  logic                    clk_enabled_r, clk_halted_r, count_down_r;
  logic                    line_a_r, line_b_r;
  logic                    src_lvl_prev_r, line_a_prev_r, line_b_prev_r;
  logic [2:0]              ext_prev_r;
  tmrch_pkg::tmrch_cfg_cap_t  cap;
  tmrch_pkg::tmrch_cfg_wave_t wav;
  logic                    wave_mode;
  logic                    wr_cmd, wr_cfg;
  assign cap       = tmrch_pkg::tmrch_cfg_cap_t'(cfg_r);
  assign wav       = tmrch_pkg::tmrch_cfg_wave_t'(cfg_r);
  assign wave_mode = cap.wave; // RQ5
  assign wr_cmd = i_wr && (i_addr == tmrch_pkg::OFS_CHANNEL_COMMAND);
  assign wr_cfg = i_wr && (i_addr == tmrch_pkg::OFS_CHANNEL_CONFIG);

  // Command strobes, zero bits act as no-ops
  logic cmd_restart, cmd_off, cmd_on;
  assign cmd_restart = wr_cmd && i_wdata[tmrch_pkg::CMD_SOFT_RESTART];
  assign cmd_off     = wr_cmd && i_wdata[tmrch_pkg::CMD_COUNT_GATE_OFF];
  assign cmd_on      = wr_cmd && i_wdata[tmrch_pkg::CMD_COUNT_GATE_ON]
                       && !i_wdata[tmrch_pkg::CMD_COUNT_GATE_OFF]; // RQ3

  // ----------------------------------------------------------------
  // Counter clock selection, gating and invert
  // ----------------------------------------------------------------
  logic src_sel, burst_ok, src_lvl, tick;
  always_comb begin
    if (cap.count_source_sel < 3'h5) begin
      src_sel = i_internal_clk[cap.count_source_sel]; // RQ14
    end else begin
      src_sel = i_ext_clock[2'(cap.count_source_sel - 3'h5)]; // RQ14
    end
    if (cap.burst_sel == 2'h0) begin
      burst_ok = 1'b1;
    end else begin
      burst_ok = i_ext_clock[2'(cap.burst_sel - 2'h1)]; // RQ12
    end
  end

  assign src_lvl = (src_sel & burst_ok) ^ cap.count_edge_invert; // RQ13
  assign tick    = src_lvl & ~src_lvl_prev_r
                   & clk_enabled_r & ~clk_halted_r;

  // ----------------------------------------------------------------
  // Events: matches, edges, triggers
  // ----------------------------------------------------------------
  logic period_hit, a_hit, b_hit, load_a, load_b, cap_trig;
  logic event_src_prev, event_src_cur, ext_event, line_b_input;
  logic period_restart, any_trig, updown;
  assign period_hit = tick && (count_r == period_r);
  assign a_hit      = tick && (count_r == compare_a_r);
  assign b_hit      = tick && (count_r == latch_b_r);
  assign load_a = !wave_mode && edge_hit(cap.latch_a_edge_sel,
                                         line_a_prev_r, i_io_line_a); // RQ6
  assign load_b = !wave_mode && edge_hit(cap.latch_b_edge_sel,
                                         line_a_prev_r, i_io_line_a); // RQ6

  assign cap_trig = !wave_mode && (cap.trigger_line_sel // RQ8
                    ? edge_hit(cap.trigger_edge_sel, line_a_prev_r,
                               i_io_line_a)
                    : edge_hit(cap.trigger_edge_sel, line_b_prev_r,
                               i_io_line_b)); // RQ9

  always_comb begin
    if (wav.event_source_sel == 2'h0) begin
      event_src_prev = line_b_prev_r; // RQ19
      event_src_cur  = i_io_line_b;
    end else begin
      event_src_prev = ext_prev_r[2'(wav.event_source_sel - 2'h1)];
      event_src_cur  = i_ext_clock[2'(wav.event_source_sel - 2'h1)];
    end
  end

  assign ext_event    = wave_mode && edge_hit(wav.event_edge_sel,
                        event_src_prev, event_src_cur); // RQ20
  assign line_b_input = wav.event_source_sel == 2'h0; // RQ19
  assign updown       = wav.count_shape_sel[0];
  assign period_restart = period_hit && (wave_mode
                          ? wav.count_shape_sel[1] // RQ17
                          : cap.period_match_restart); // RQ7
  assign any_trig = cmd_restart || cap_trig // RQ1
                    || (ext_event && wav.event_restart_enable); // RQ18

  // ----------------------------------------------------------------
  // Register port writes
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_r <= tmrch_pkg::RST_CHANNEL_CONFIG;
    end else if (i_ce && wr_cfg) begin
      cfg_r <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      period_r <= tmrch_pkg::RST_COUNT;
    end else if (i_ce && i_wr && i_addr == tmrch_pkg::OFS_PERIOD_REG) begin
      period_r <= i_wdata[15:0];
    end
  end

  // A and B take software writes in waveform view, edge loads in capture
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      compare_a_r <= tmrch_pkg::RST_COUNT;
      latch_b_r   <= tmrch_pkg::RST_COUNT;
    end else if (i_ce) begin
      if (load_a) begin
        compare_a_r <= count_r; // RQ6
      end else if (wave_mode && i_wr
                   && i_addr == tmrch_pkg::OFS_COMPARE_A) begin
        compare_a_r <= i_wdata[15:0];
      end
      if (load_b) begin
        latch_b_r <= count_r; // RQ6
      end else if (wave_mode && i_wr
                   && i_addr == tmrch_pkg::OFS_LATCH_B) begin
        latch_b_r <= i_wdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock enable and halt state
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clk_enabled_r <= 1'b0;
    end else if (i_ce) begin
      if (cmd_off) begin
        clk_enabled_r <= 1'b0; // RQ2
      end else if (!wave_mode && cap.latch_b_gate_off && load_b) begin
        clk_enabled_r <= 1'b0; // RQ10
      end else if (wave_mode && wav.period_gate_off && period_hit) begin
        clk_enabled_r <= 1'b0; // RQ21
      end else if (cmd_on) begin
        clk_enabled_r <= 1'b1; // RQ3
      end
    end
  end

  // A halt beats a same-cycle restart; triggers never re-enable
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clk_halted_r <= 1'b0;
    end else if (i_ce) begin
      if (!wave_mode && cap.latch_b_halt && load_b) begin
        clk_halted_r <= 1'b1; // RQ11
      end else if (wave_mode && wav.period_halt && period_hit) begin
        clk_halted_r <= 1'b1; // RQ22
      end else if (any_trig || period_restart) begin
        clk_halted_r <= 1'b0; // RQ24
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter and direction
  // ----------------------------------------------------------------
  logic [15:0] turn_top;
  assign turn_top = wav.count_shape_sel[1] ? period_r
                                           : tmrch_pkg::COUNT_TOP; // RQ23

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_r      <= tmrch_pkg::RST_COUNT;
      count_down_r <= 1'b0;
    end else if (i_ce) begin
      if (!wave_mode || !updown) begin
        count_down_r <= 1'b0;
        if (any_trig || period_restart) begin
          count_r <= tmrch_pkg::RST_COUNT; // RQ1
        end else if (tick) begin
          count_r <= count_r + 16'h0001;
        end
      end else if (any_trig) begin
        count_down_r <= ~count_down_r; // RQ23
      end else if (tick) begin
        if (!count_down_r && count_r >= turn_top) begin
          count_down_r <= 1'b1; // RQ17
          count_r      <= count_r - 16'h0001;
        end else if (count_down_r && count_r == tmrch_pkg::RST_COUNT) begin
          count_down_r <= 1'b0;
          count_r      <= count_r + 16'h0001;
        end else if (count_down_r) begin
          count_r <= count_r - 16'h0001;
        end else begin
          count_r <= count_r + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Output line controllers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      line_a_r <= 1'b0;
      line_b_r <= 1'b0;
    end else if (i_ce && wave_mode) begin
      if (cmd_restart && wav.line_a_soft_action != tmrch_pkg::ACT_NONE) begin
        line_a_r <= apply_act(wav.line_a_soft_action, line_a_r); // RQ16
      end else if (ext_event
                   && wav.line_a_event_action != tmrch_pkg::ACT_NONE) begin
        line_a_r <= apply_act(wav.line_a_event_action, line_a_r); // RQ16
      end else if (period_hit
                   && wav.line_a_period_action != tmrch_pkg::ACT_NONE) begin
        line_a_r <= apply_act(wav.line_a_period_action, line_a_r); // RQ16
      end else if (a_hit) begin
        line_a_r <= apply_act(wav.line_a_match_action, line_a_r); // RQ16
      end
      if (line_b_input) begin
        line_b_r <= line_b_r;
      end else if (cmd_restart
                   && wav.line_b_soft_action != tmrch_pkg::ACT_NONE) begin
        line_b_r <= apply_act(wav.line_b_soft_action, line_b_r); // RQ15
      end else if (ext_event
                   && wav.line_b_event_action != tmrch_pkg::ACT_NONE) begin
        line_b_r <= apply_act(wav.line_b_event_action, line_b_r); // RQ15
      end else if (period_hit
                   && wav.line_b_period_action != tmrch_pkg::ACT_NONE) begin
        line_b_r <= apply_act(wav.line_b_period_action, line_b_r); // RQ15
      end else if (b_hit) begin
        line_b_r <= apply_act(wav.line_b_match_action, line_b_r); // RQ15
      end
    end
  end

  tmrch_pkg::tmrch_pin_t pin_a, pin_b;
  assign pin_a = '{out: line_a_r, oe_n: !wave_mode};
  assign pin_b = '{out: line_b_r, oe_n: !wave_mode || line_b_input};
  assign o_io_line_a      = pin_a.out;
  assign o_io_line_a_oe_n = pin_a.oe_n;
  assign o_io_line_b      = pin_b.out;
  assign o_io_line_b_oe_n = pin_b.oe_n;

  // ----------------------------------------------------------------
  // Edge history
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      src_lvl_prev_r <= 1'b0;
      line_a_prev_r  <= 1'b0;
      line_b_prev_r  <= 1'b0;
      ext_prev_r     <= 3'h0;
    end else if (i_ce) begin
      src_lvl_prev_r <= src_lvl;
      line_a_prev_r  <= i_io_line_a;
      line_b_prev_r  <= i_io_line_b;
      ext_prev_r     <= i_ext_clock;
    end
  end

  // ----------------------------------------------------------------
  // Read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  logic [31:0] status, rd_nxt;
  always_comb begin
    status = 32'h0000_0000;
    status[tmrch_pkg::STA_CLK_ENABLED] = clk_enabled_r;
    status[tmrch_pkg::STA_MIRROR_A] = wave_mode ? line_a_r : i_io_line_a;
    status[tmrch_pkg::STA_MIRROR_B] =
      (wave_mode && !line_b_input) ? line_b_r : i_io_line_b;
    case (i_addr)
      tmrch_pkg::OFS_CHANNEL_CONFIG: rd_nxt = cfg_r;
      tmrch_pkg::OFS_COUNT_VALUE:    rd_nxt = {16'h0000, count_r};
      tmrch_pkg::OFS_COMPARE_A:      rd_nxt = {16'h0000, compare_a_r};
      tmrch_pkg::OFS_LATCH_B:        rd_nxt = {16'h0000, latch_b_r};
      tmrch_pkg::OFS_PERIOD_REG:     rd_nxt = {16'h0000, period_r};
      tmrch_pkg::OFS_CHANNEL_STATUS: rd_nxt = status;
      default:                       rd_nxt = 32'h0000_0000; // RQ4
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_ce) begin
      o_rdata <= i_rd ? rd_nxt : 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

//--- shared/tmrch_pkg.sv
/*
  Package for one 16-bit timer channel: register offsets, command bit
  positions, mode field layouts, reset values and code enumerations.
  Assumes a single 20 MHz clock domain and a plain register port.
*/
`default_nettype none
package tmrch_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CHANNEL_COMMAND = 8'h00;
  localparam logic [7:0] OFS_CHANNEL_CONFIG  = 8'h04;
  localparam logic [7:0] OFS_COUNT_VALUE     = 8'h10;
  localparam logic [7:0] OFS_COMPARE_A       = 8'h14;
  localparam logic [7:0] OFS_LATCH_B         = 8'h18;
  localparam logic [7:0] OFS_PERIOD_REG      = 8'h1c;
  localparam logic [7:0] OFS_CHANNEL_STATUS  = 8'h20;

  // ----------------------------------------------------------------
  // Command bits, status bits and reset values
  // ----------------------------------------------------------------
  localparam int CMD_COUNT_GATE_ON  = 0;
  localparam int CMD_COUNT_GATE_OFF = 1;
  localparam int CMD_SOFT_RESTART   = 2;
  localparam int STA_CLK_ENABLED    = 16;
  localparam int STA_MIRROR_A       = 17;
  localparam int STA_MIRROR_B       = 18;
  localparam logic [31:0] RST_CHANNEL_CONFIG = 32'h0000_0000;
  localparam logic [15:0] RST_COUNT          = 16'h0000;
  localparam logic [15:0] COUNT_TOP          = 16'hffff;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00, EDGE_RISE = 2'b01, EDGE_FALL = 2'b10, EDGE_ANY = 2'b11
  } tmrch_edge_t;

  typedef enum logic [1:0] {
    ACT_NONE = 2'b00, ACT_SET = 2'b01, ACT_CLEAR = 2'b10, ACT_TOGGLE = 2'b11
  } tmrch_act_t;

  typedef enum logic [1:0] {
    SHAPE_UP = 2'b00, SHAPE_UPDN = 2'b01,
    SHAPE_UP_TRIG = 2'b10, SHAPE_UPDN_TRIG = 2'b11
  } tmrch_shape_t;

  // ----------------------------------------------------------------
  // Channel config views, bit 31 first
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0]  unused_hi;
    tmrch_edge_t  latch_b_edge_sel;
    tmrch_edge_t  latch_a_edge_sel;
    logic         wave;
    logic         period_match_restart;
    logic [2:0]   unused_mid;
    logic         trigger_line_sel;
    tmrch_edge_t  trigger_edge_sel;
    logic         latch_b_gate_off;
    logic         latch_b_halt;
    logic [1:0]   burst_sel;
    logic         count_edge_invert;
    logic [2:0]   count_source_sel;
  } tmrch_cfg_cap_t;

  typedef struct packed {
    tmrch_act_t   line_b_soft_action;
    tmrch_act_t   line_b_event_action;
    tmrch_act_t   line_b_period_action;
    tmrch_act_t   line_b_match_action;
    tmrch_act_t   line_a_soft_action;
    tmrch_act_t   line_a_event_action;
    tmrch_act_t   line_a_period_action;
    tmrch_act_t   line_a_match_action;
    logic         wave;
    tmrch_shape_t count_shape_sel;
    logic         event_restart_enable;
    logic [1:0]   event_source_sel;
    tmrch_edge_t  event_edge_sel;
    logic         period_gate_off;
    logic         period_halt;
    logic [1:0]   burst_sel;
    logic         count_edge_invert;
    logic [2:0]   count_source_sel;
  } tmrch_cfg_wave_t;

  // Pin pair (out, oe_n) for a two-way line
  typedef struct packed {
    logic out;
    logic oe_n;
  } tmrch_pin_t;

endpackage
`default_nettype wire

//--- sim/tmrch_pins_model.sv
/*
  Far-side pin model: internal and external clock levels and line pins.
  Assumes the bench calls pulse() from its own thread, one at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module tmrch_pins_model (
  input  wire logic       i_clk,
  input  wire logic       i_out_a,
  input  wire logic       i_oe_a_n,
  input  wire logic       i_out_b,
  input  wire logic       i_oe_b_n,
  output logic      [4:0] o_internal_clk,
  output logic      [2:0] o_ext_clock,
  output logic            o_line_a,
  output logic            o_line_b
);
  // ----------------------------------------------------------
  // Levels: bits 4:0 internal, 7:5 external, 8 line A, 9 line B
  // ----------------------------------------------------------
  logic [9:0] drv = 10'h000;
  assign o_internal_clk = drv[4:0];
  assign o_ext_clock    = drv[7:5];
  // Wire level from whoever drives it
  assign o_line_a = i_oe_a_n ? drv[8] : i_out_a;
  assign o_line_b = i_oe_b_n ? drv[9] : i_out_b;
  // Each source stays one cycle high and one low
  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      @(posedge i_clk);
      drv[idx] <= 1'b1;
      @(posedge i_clk);
      drv[idx] <= 1'b0;
    end
    repeat (2) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

//--- sim/tmrch_channel_asserts.sv
/*
  Port checker for the timer channel.
  Assumes it is bound to the channel top with every port by name.
*/
`timescale 1ns/1ps
`default_nettype none
module tmrch_channel_asserts (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_ce,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        o_io_line_a_oe_n,
  input wire logic        o_io_line_b_oe_n
);
  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic cmd_w;
  assign cmd_w = i_wr && i_addr == tmrch_pkg::OFS_CHANNEL_COMMAND;
  logic cfg_w;
  assign cfg_w = i_wr && i_ce && i_addr == tmrch_pkg::OFS_CHANNEL_CONFIG;
  logic sta_r;
  assign sta_r = i_rd && i_addr == tmrch_pkg::OFS_CHANNEL_STATUS;
  logic cnt_r;
  assign cnt_r = i_rd && i_addr == tmrch_pkg::OFS_COUNT_VALUE;

  a_rdata_idle_zero: assert property ($past(i_ce) && !$past(i_rd)
    |-> o_rdata == 32'h0) else $error("read data not idle zero");
  a_cmd_reads_zero: assert property (i_rd && i_addr == 8'h00 |=>
    o_rdata == 32'h0) else $error("command register read nonzero");
  a_mode_sets_oe_a: assert property ($past(cfg_w) |->
    o_io_line_a_oe_n == !$past(i_wdata[15])) else $error("line A oe");
  a_src_sets_oe_b: assert property ($past(cfg_w) |->
    o_io_line_b_oe_n == !($past(i_wdata[15]) && $past(i_wdata[11:10]) != 2'h0))
    else $error("line B oe");
  a_gate_off_cmd: assert property (cmd_w && i_wdata[1] ##1 !i_wr
    ##1 sta_r |=> !o_rdata[16]) else $error("clock not disabled");
  a_gate_on_cmd: assert property (cmd_w && i_wdata[1:0] == 2'h1
    ##1 !i_wr ##1 sta_r |=> o_rdata[16]) else $error("clock not enabled");
  a_soft_clears_count: assert property (cmd_w && i_wdata[2]
    ##1 !i_wr ##1 cnt_r |=> o_rdata[15:0] <= 16'h0001)
    else $error("count not cleared by soft restart");
  a_count_upper_zero: assert property (cnt_r |=> o_rdata[31:16] == 16'h0)
    else $error("count upper bits nonzero");
endmodule
`default_nettype wire

//--- sim/tmrch_channel_tb.sv
/*
  Self-checking bench for the timer channel, one task per scenario.
  Assumes the pin model file and checker file compile before this one.
*/
`timescale 1ns/1ps
`default_nettype none
module tmrch_channel_tb;
  // ----------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------
  logic        i_clk, i_rst_n, i_wr, i_rd, la, lb, oa, ob, oea_n, oeb_n, ce;
  logic [7:0]  i_addr;
  logic [4:0]  ic;
  logic [2:0]  ec;
  logic [31:0] i_wdata, o_rdata, v;
  int          n_mismatch, checks_done;
  tmrch_channel u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_internal_clk(ic), .i_ext_clock(ec),
    .i_io_line_a(la), .o_io_line_a(oa), .o_io_line_a_oe_n(oea_n),
    .i_io_line_b(lb), .o_io_line_b(ob), .o_io_line_b_oe_n(oeb_n));
  tmrch_pins_model u_pins (.i_clk(i_clk), .i_out_a(oa), .i_oe_a_n(oea_n),
    .i_out_b(ob), .i_oe_b_n(oeb_n), .o_internal_clk(ic),
    .o_ext_clock(ec), .o_line_a(la), .o_line_b(lb));
  // ----------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
  endtask
  task automatic stat(input logic e);
    rd(tmrch_pkg::OFS_CHANNEL_STATUS);
    chk(v[tmrch_pkg::STA_CLK_ENABLED], e);
  endtask
  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_reset();
    rd(tmrch_pkg::OFS_CHANNEL_CONFIG);
    chk(v, tmrch_pkg::RST_CHANNEL_CONFIG);
    rd(8'h00);
    chk(v, 32'h0);
    rd(8'h30);
    chk(v, 32'h0);
    stat(1'b0);
    chk(oea_n, 1'b1);
  endtask
  task automatic t_cmd();
    wr(8'h00, 32'h1);
    stat(1'b1);
    wr(8'h00, 32'h0);
    stat(1'b1);
    wr(8'h00, 32'h3);
    stat(1'b0);
    wr(8'h00, 32'h1);
    wr(8'h00, 32'h2);
    stat(1'b0);
    wr(8'h00, 32'h4);
    rd(tmrch_pkg::OFS_COUNT_VALUE);
    chk(v, 32'h0);
    stat(1'b0);
  endtask
  task automatic t_wave();
    logic [31:0] c;
    wr(tmrch_pkg::OFS_CHANNEL_CONFIG, 32'h004cc445);
    rd(tmrch_pkg::OFS_CHANNEL_CONFIG);
    chk(v, 32'h004cc445);
    chk({oea_n, oeb_n}, 32'h0);
    wr(tmrch_pkg::OFS_PERIOD_REG, 32'h3);
    wr(8'h00, 32'h1);
    wr(8'h00, 32'h4);
    chk(oa, 1'b1);
    u_pins.pulse(5, 4);
    chk(oa, 1'b0);
    rd(tmrch_pkg::OFS_COUNT_VALUE);
    c = v;
    u_pins.pulse(5, 2);
    rd(tmrch_pkg::OFS_COUNT_VALUE);
    chk(v, c);
    wr(8'h00, 32'h4);
    u_pins.pulse(5, 1);
    rd(tmrch_pkg::OFS_COUNT_VALUE);
    chk(v, 32'h1);
    wr(tmrch_pkg::OFS_CHANNEL_CONFIG, 32'h004cc485);
    wr(8'h00, 32'h4);
    u_pins.pulse(5, 4);
    stat(1'b0);
    wr(8'h00, 32'h4);
    stat(1'b0);
  endtask
  task automatic t_capture();
    wr(tmrch_pkg::OFS_CHANNEL_CONFIG, 32'h0009008d);
    chk(oeb_n, 1'b1);
    wr(8'h00, 32'h1);
    wr(8'h00, 32'h4);
    u_pins.pulse(5, 5);
    u_pins.pulse(8, 1);
    rd(tmrch_pkg::OFS_COMPARE_A);
    chk(v, 32'h5);
    rd(tmrch_pkg::OFS_LATCH_B);
    chk(v, 32'h5);
    stat(1'b0);
  endtask
  task automatic t_updown();
    wr(8'h00, 32'h4);
    wr(tmrch_pkg::OFS_CHANNEL_CONFIG, 32'hc000a805);
    wr(8'h00, 32'h1);
    u_pins.pulse(5, 3);
    wr(8'h00, 32'h4);
    chk(ob, 1'b1);
    u_pins.pulse(5, 2);
    rd(tmrch_pkg::OFS_COUNT_VALUE);
    chk(v, 32'h1);
  endtask
  task automatic t_freeze();
    @(posedge i_clk);
    ce <= 1'b0;
    wr(tmrch_pkg::OFS_PERIOD_REG, 32'h9);
    @(posedge i_clk);
    ce <= 1'b1;
    rd(tmrch_pkg::OFS_PERIOD_REG);
    chk(v, 32'h3);
  endtask
  // ----------------------------------------------------------
  // Sequence, clock, watchdog, verdict
  // ----------------------------------------------------------
  task automatic summarize();
    $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  initial begin
    #2000000;
    n_mismatch++;
    summarize();
  end
  initial begin
    {i_rst_n, i_wr, i_rd, i_addr, i_wdata} = '0;
    ce = 1'b1;
    n_mismatch  = 0;
    checks_done = 0;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_cmd();
    t_wave();
    t_capture();
    t_updown();
    t_freeze();
    summarize();
  end
endmodule
bind tmrch_channel tmrch_channel_asserts u_chk (.i_clk(i_clk),
  .i_rst_n(i_rst_n), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_io_line_a_oe_n(o_io_line_a_oe_n), .o_io_line_b_oe_n(o_io_line_b_oe_n));
`default_nettype wire
